// ===== shared/ac_fire_regs.vh
`ifndef AC_FIRE_REGS_VH
`define AC_FIRE_REGS_VH

// Register byte offsets on the APB
`define REG_CTRL 8'h00
`define REG_SETPOINT 8'h04
`define REG_DELAY 8'h08
`define REG_BURST 8'h0C
`define REG_RAMP 8'h10
`define REG_STATUS 8'h14

// Field positions
`define CTRL_MODE_LSB 0
`define DELAY_ANGLE_LSB 0
`define DELAY_HALVES_LSB 8
`define BURST_MIN_LSB 0
`define RAMP_DUR_LSB 0
`define STAT_LEVEL_LSB 0
`define STAT_BURST_ON 8
`define STAT_HALF_FIRE 9
`define STAT_GATE 10
`define STAT_POSITIVE 11
`define STAT_ENABLE 12

// Firing modes
`define MODE_BURST_DELAYED 2'h0
`define MODE_HALF_CYCLE 2'h1
`define MODE_ANGLE 2'h2
`define MODE_ANGLE_RAMPED 2'h3

// Reset values
`define CTRL_RESET 2'h0
`define SETPOINT_RESET 7'h00
`define DELAY_ANGLE_RESET 8'h50
`define DELAY_HALVES_RESET 8'h01
`define MIN_CYCLES_RESET 8'h01
`define RAMP_DUR_RESET 8'h00

// Scale constants
`define PCT_FULL 7'h64
`define DEG_HALF 8'hB4

// Timing: one ramp step is 50 ms at an 8 ns clock
`define RAMP_STEP_MS 32'h00000032
`define CLK_PERIOD_NS 32'h00000008
`define NS_PER_MS 32'h000F4240
`define RAMP_STEP_CYCLES (`RAMP_STEP_MS * `NS_PER_MS / `CLK_PERIOD_NS)

`endif

// ===== src/zc_tracker.v
`timescale 1ns/100ps
`default_nettype none
`include "ac_fire_regs.vh"

module zc_tracker (
  input wire clk_sys,
  input wire rstn,
  input wire zeroCrossIn,
  output reg halfStart,
  output reg positiveHalf,
  output reg [7:0] angle
);

  reg zcMeta;
  reg zcStable;
  reg zcLast;
  reg [23:0] halfCount;
  reg [23:0] period;
  reg [24:0] degAcc;
  wire [24:0] degSum = degAcc + {17'h00000, `DEG_HALF};

  // Angle ticks 180 times per half cycle, scaled by the last measured half period
  always @(posedge clk_sys) begin
    if (!rstn) begin
      zcMeta <= 1'b0;
      zcStable <= 1'b0;
      zcLast <= 1'b0;
      halfCount <= 24'h000000;
      period <= 24'hFFFFFF;
      degAcc <= 25'h0000000;
      halfStart <= 1'b0;
      positiveHalf <= 1'b0;
      angle <= 8'h00;
    end else begin
      zcMeta <= zeroCrossIn;
      zcStable <= zcMeta;
      zcLast <= zcStable;
      halfStart <= 1'b0;
      if (zcStable != zcLast) begin
        period <= halfCount + 24'h000001;
        halfCount <= 24'h000000;
        degAcc <= 25'h0000000;
        angle <= 8'h00;
        halfStart <= 1'b1;
        positiveHalf <= zcStable;
      end else begin
        if (halfCount != 24'hFFFFFF)
          halfCount <= halfCount + 24'h000001;
        if (degSum >= {1'b0, period}) begin
          degAcc <= degSum - {1'b0, period};
          // Saturate so a lost crossing never wraps back to an early angle
          if (angle < `DEG_HALF - 8'h01)
            angle <= angle + 8'h01;
        end else begin
          degAcc <= degSum;
        end
      end
    end
  end

endmodule // zc_tracker
`default_nettype wire

// ===== src/soft_ramp.v
`timescale 1ns/100ps
`default_nettype none
`include "ac_fire_regs.vh"

module soft_ramp #(
  parameter [31:0] STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  input wire clk_sys,
  input wire rstn,
  input wire [6:0] target,
  input wire [7:0] duration,
  input wire bypass,
  input wire enable,
  output reg [6:0] level
);

  reg enableLast;
  reg [39:0] stepAcc;
  // Full scale (100 steps) spans the whole ramp time
  wire [39:0] limit = {32'h00000000, duration} * {8'h00, STEP_CYCLES};
  wire [39:0] next_stepAcc = stepAcc + 40'h0000000064;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      enableLast <= 1'b0;
      stepAcc <= 40'h0000000000;
      level <= 7'h00;
    end else begin
      enableLast <= enable;
      if (!enable) begin
        level <= 7'h00;
        stepAcc <= 40'h0000000000;
      end else if (bypass || duration == 8'h00) begin
        level <= target;
        stepAcc <= 40'h0000000000;
      end else if (!enableLast) begin
        level <= 7'h00;
        stepAcc <= 40'h0000000000;
      end else if (level != target) begin
        if (next_stepAcc >= limit) begin
          stepAcc <= 40'h0000000000;
          level <= (level < target) ? level + 7'h01 : level - 7'h01;
        end else begin
          stepAcc <= next_stepAcc;
        end
      end else begin
        stepAcc <= 40'h0000000000;
      end
    end
  end

endmodule // soft_ramp
`default_nettype wire

// ===== src/ac_load_firing_control.v
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ac_fire_regs.vh"

module ac_load_firing_control #(
  parameter [31:0] RAMP_STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire zeroCrossIn,
  input wire enableIn,
  output reg gateDrive
);

  // Demand above full scale is held at full scale
  function [6:0] clampPct;
    input [7:0] raw;
    begin
      clampPct = (raw > {1'b0, `PCT_FULL}) ? `PCT_FULL : raw[6:0];
    end
  endfunction

  // Firing angle in degrees for a demand: 180 - demand * 180 / 100
  function [7:0] fireAngleOf;
    input [6:0] pct;
    reg [9:0] scaled;
    begin
      scaled = ({3'h0, pct} * 10'h009) / 10'h005;
      fireAngleOf = `DEG_HALF - scaled[7:0];
    end
  endfunction

  // A zero minimum would never close a block, so it counts as one
  function [7:0] atLeastOne;
    input [7:0] value;
    begin
      atLeastOne = (value == 8'h00) ? 8'h01 : value;
    end
  endfunction

  reg [1:0] mode;
  reg [6:0] setPoint;
  reg [7:0] delayAngle;
  reg [7:0] delayedHalfCycleCount;
  reg [7:0] minOnOffCycles;
  reg [7:0] rampDuration;

  reg enMeta;
  reg enSync;

  wire halfStart;
  wire positiveHalf;
  wire [7:0] angle;
  wire [6:0] rampLevel;

  reg burstOn;
  reg [7:0] blockLeft;
  reg [7:0] burstAcc;
  reg [7:0] delayLeft;
  reg [8:0] halfAcc;
  reg lastPolarity;
  reg halfFire;
  reg [7:0] halfAngle;

  reg next_burstOn;
  reg [7:0] next_blockLeft;
  reg [7:0] next_burstAcc;
  reg [7:0] next_delayLeft;
  reg [7:0] burstSum;
  reg next_halfFireHc;
  reg [8:0] next_halfAcc;
  reg [8:0] halfSum;

  wire apbAccess = psel && penable;
  wire apbDone = apbAccess && pready;
  wire addrMapped = (paddr == `REG_CTRL) || (paddr == `REG_SETPOINT) ||
    (paddr == `REG_DELAY) || (paddr == `REG_BURST) ||
    (paddr == `REG_RAMP) || (paddr == `REG_STATUS);

  zc_tracker tracker (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .zeroCrossIn(zeroCrossIn),
    .halfStart(halfStart),
    .positiveHalf(positiveHalf),
    .angle(angle)
  );

  soft_ramp #(
    .STEP_CYCLES(RAMP_STEP_CYCLES)
  ) ramp (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .target(setPoint),
    .duration(rampDuration),
    .bypass(mode == `MODE_ANGLE),
    .enable(enSync),
    .level(rampLevel)
  );

  // Enable arrives from a pin
  always @(posedge clk_sys) begin
    if (!rstn) begin
      enMeta <= 1'b0;
      enSync <= 1'b0;
    end else begin
      enMeta <= enableIn;
      enSync <= enMeta;
    end
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbAccess && !pready;
      if (apbAccess && !pready) begin
        pslverr <= !addrMapped;
        prdata <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            `REG_CTRL: prdata[`CTRL_MODE_LSB +: 2] <= mode;
            `REG_SETPOINT: prdata[6:0] <= setPoint;
            `REG_DELAY: begin
              prdata[`DELAY_ANGLE_LSB +: 8] <= delayAngle;
              prdata[`DELAY_HALVES_LSB +: 8] <= delayedHalfCycleCount;
            end
            `REG_BURST: prdata[`BURST_MIN_LSB +: 8] <= minOnOffCycles;
            `REG_RAMP: prdata[`RAMP_DUR_LSB +: 8] <= rampDuration;
            `REG_STATUS: begin
              prdata[`STAT_LEVEL_LSB +: 7] <= rampLevel;
              prdata[`STAT_BURST_ON] <= burstOn;
              prdata[`STAT_HALF_FIRE] <= halfFire;
              prdata[`STAT_GATE] <= gateDrive;
              prdata[`STAT_POSITIVE] <= positiveHalf;
              prdata[`STAT_ENABLE] <= enSync;
            end
            default: prdata <= 32'h00000000;
          endcase
        end
      end else if (!apbAccess) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Writes land only at the edge that completes the access
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mode <= `CTRL_RESET;
      setPoint <= `SETPOINT_RESET;
      delayAngle <= `DELAY_ANGLE_RESET;
      delayedHalfCycleCount <= `DELAY_HALVES_RESET;
      minOnOffCycles <= `MIN_CYCLES_RESET;
      rampDuration <= `RAMP_DUR_RESET;
    end else if (apbDone && pwrite) begin
      case (paddr)
        `REG_CTRL: mode <= pwdata[`CTRL_MODE_LSB +: 2];
        `REG_SETPOINT: setPoint <= clampPct(pwdata[7:0]);
        `REG_DELAY: begin
          // Angles past the half cycle would never fire
          delayAngle <= (pwdata[7:0] >= `DEG_HALF) ? `DEG_HALF - 8'h01 : pwdata[7:0];
          delayedHalfCycleCount <= pwdata[`DELAY_HALVES_LSB +: 8];
        end
        `REG_BURST: minOnOffCycles <= pwdata[`BURST_MIN_LSB +: 8];
        `REG_RAMP: rampDuration <= pwdata[`RAMP_DUR_LSB +: 8];
        default: mode <= mode;
      endcase
    end
  end

  // Burst decision, taken once per block of min cycles at the positive half start
  always @* begin
    next_burstOn = burstOn;
    next_blockLeft = blockLeft;
    next_burstAcc = burstAcc;
    next_delayLeft = delayLeft;
    burstSum = burstAcc + {1'b0, rampLevel};
    if (positiveHalf) begin
      if (blockLeft <= 8'h01) begin
        // Blocks of min cycles keep every on and off run at least that long
        next_blockLeft = atLeastOne(minOnOffCycles);
        if (burstSum >= {1'b0, `PCT_FULL}) begin
          next_burstOn = 1'b1;
          next_burstAcc = burstSum - {1'b0, `PCT_FULL};
        end else begin
          next_burstOn = 1'b0;
          next_burstAcc = burstSum;
        end
        if (next_burstOn && !burstOn)
          next_delayLeft = delayedHalfCycleCount;
      end else begin
        next_blockLeft = blockLeft - 8'h01;
      end
    end
  end

  // Half-cycle decision with polarity alternation
  always @* begin
    halfSum = halfAcc + {2'h0, rampLevel};
    next_halfFireHc = 1'b0;
    next_halfAcc = halfSum;
    if (halfSum >= {2'h0, `PCT_FULL}) begin
      // A due half of the same polarity as the last fired one waits a half
      if (positiveHalf != lastPolarity) begin
        next_halfFireHc = 1'b1;
        next_halfAcc = halfSum - {2'h0, `PCT_FULL};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      burstOn <= 1'b0;
      blockLeft <= 8'h00;
      burstAcc <= 8'h00;
      delayLeft <= 8'h00;
      halfAcc <= 9'h000;
      lastPolarity <= 1'b0;
      halfFire <= 1'b0;
      halfAngle <= 8'h00;
    end else if (!enSync) begin
      // Next enable starts a fresh burst, so its first halves are delayed again
      burstOn <= 1'b0;
      blockLeft <= 8'h00;
      burstAcc <= 8'h00;
      delayLeft <= 8'h00;
      halfAcc <= 9'h000;
      halfFire <= 1'b0;
    end else if (halfStart) begin
      case (mode)
        `MODE_BURST_DELAYED: begin
          burstOn <= next_burstOn;
          blockLeft <= next_blockLeft;
          burstAcc <= next_burstAcc;
          halfFire <= next_burstOn;
          if (next_burstOn && next_delayLeft != 8'h00) begin
            halfAngle <= delayAngle;
            delayLeft <= next_delayLeft - 8'h01;
          end else begin
            halfAngle <= 8'h00;
            delayLeft <= 8'h00;
          end
        end
        `MODE_HALF_CYCLE: begin
          halfFire <= next_halfFireHc;
          halfAcc <= next_halfAcc;
          halfAngle <= 8'h00;
          if (next_halfFireHc)
            lastPolarity <= positiveHalf;
        end
        `MODE_ANGLE, `MODE_ANGLE_RAMPED: begin
          halfFire <= (rampLevel != 7'h00);
          halfAngle <= fireAngleOf(rampLevel);
        end
        default: halfFire <= 1'b0;
      endcase
    end
  end

  // Gate holds from the firing angle to the next zero crossing
  always @(posedge clk_sys) begin
    if (!rstn) begin
      gateDrive <= 1'b0;
    end else if (!enSync) begin
      gateDrive <= 1'b0;
    end else begin
      gateDrive <= halfFire && (angle >= halfAngle);
    end
  end

endmodule // ac_load_firing_control
`default_nettype wire

// ===== testbench/ac_fire_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ac_fire_chk #(
  parameter [31:0] RAMP_STEP_CYCLES = 32'h005F5E10
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic zeroCrossIn,
  input wire logic enableIn,
  input wire logic gateDrive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Cycles since the last line edge, held at zero while disabled
  logic [7:0] quiet;
  logic zcPrev;
  always @(posedge clk_sys) begin
    zcPrev <= zeroCrossIn;
    if (!rstn || !enableIn || zcPrev != zeroCrossIn) quiet <= 8'h00;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
  end
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_access;
    pready |-> psel && penable;
  endproperty
  a_access: assert property (p_access) else $error("ready outside access");
  property p_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_err;
    $rose(pslverr) |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmapped;
    pready && !pwrite && paddr > 8'h14 |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_mapped;
    pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_off;
    !enableIn [*5] |-> !gateDrive;
  endproperty
  a_off: assert property (p_off) else $error("gate on while disabled");
  property p_fall;
    $fell(gateDrive) |-> quiet <= 8'h08;
  endproperty
  a_fall: assert property (p_fall) else $error("gate fell mid half");
  property p_reset;
    disable iff (1'b0) !rstn |=> !pready && !pslverr && !gateDrive;
  endproperty
  a_reset: assert property (p_reset) else $error("output active in reset");
endmodule // ac_fire_chk
bind ac_load_firing_control ac_fire_chk #(.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) chk (
  .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .zeroCrossIn(zeroCrossIn), .enableIn(enableIn), .gateDrive(gateDrive));
`default_nettype wire

// ===== testbench/mains_stage.sv
`timescale 1ns/100ps
`default_nettype none
module mains_stage #(
  parameter int HALF = 360
) (
  input wire logic clk_sys,
  input wire logic gateDrive,
  output var logic zeroCrossIn,
  output var int onHalves,
  output var int posOn,
  output var int negOn,
  output var int riseAt,
  output var int burstRise,
  output var int contRise,
  output var int lastRun
);
  int cnt;
  int run;
  logic zcLevel = 1'b0;
  logic cond = 1'b0;
  logic prevOn = 1'b0;
  assign zeroCrossIn = zcLevel;
  always @(posedge clk_sys) begin
    cnt <= cnt + 1;
    // Skip the first cycles so a gate tail from the last half is not taken as a fire
    if (gateDrive && !cond && cnt >= 8) begin
      cond <= 1'b1;
      riseAt <= cnt;
    end
    if (cnt == HALF - 1) begin
      cnt <= 0;
      zcLevel <= ~zcLevel;
      cond <= 1'b0; // Thyristor stops at the current zero
      prevOn <= cond;
      run <= cond ? run + 1 : 0;
      if (cond) begin
        onHalves <= onHalves + 1;
        if (zcLevel) posOn <= posOn + 1;
        else negOn <= negOn + 1;
        if (prevOn) contRise <= riseAt;
        else burstRise <= riseAt;
      end
      else if (prevOn) lastRun <= run;
    end
  end
endmodule // mains_stage
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ac_fire_regs.vh"
module tb_top;
  localparam int HALF = 360;
  logic clk_sys, rstn, psel, penable, pwrite, enableIn, pready, pslverr, gateDrive, err;
  logic zeroCrossIn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, compares, onHalves, posOn, negOn, riseAt, burstRise, contRise, lastRun;
  int n0, p;
  logic [7:0] ra[4] = '{`REG_CTRL, `REG_DELAY, `REG_BURST, `REG_RAMP};
  logic [31:0] rv[4] = '{32'h0, 32'h00000150, 32'h1, 32'h0};
  int pa[3] = '{25, 50, 75};
  ac_load_firing_control #(.RAMP_STEP_CYCLES(32'h00000064)) dut (.clk_sys(clk_sys),
    .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zeroCrossIn(zeroCrossIn), .enableIn(enableIn), .gateDrive(gateDrive));
  mains_stage #(.HALF(HALF)) line (.clk_sys(clk_sys), .gateDrive(gateDrive),
    .zeroCrossIn(zeroCrossIn), .onHalves(onHalves), .posOn(posOn), .negOn(negOn),
    .riseAt(riseAt), .burstRise(burstRise), .contRise(contRise), .lastRun(lastRun));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Only the watchdog may end a wait for ready
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic lvl(input int lo, input int hi);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk({25'h0, rd[6:0]}, lo, hi);
  endtask
  task automatic halves(input int k);
    repeat (k * HALF) @(posedge clk_sys);
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, enableIn, paddr, pwdata} = '0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i], rv[i]);
    end
    apb(1'b1, 8'h20, 32'h0000FFFF);
    chk({31'h0, err}, 1, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 0, 0);
    apb(1'b1, `REG_SETPOINT, 32'h7F);
    apb(1'b0, `REG_SETPOINT, 32'h0);
    chk(rd, 100, 100);
    // Ramp set on purpose: plain angle mode must still jump at once
    apb(1'b1, `REG_CTRL, 32'h2);
    apb(1'b1, `REG_RAMP, 32'h14);
    enableIn <= 1'b1;
    foreach (pa[i]) begin
      apb(1'b1, `REG_SETPOINT, pa[i]);
      lvl(pa[i], pa[i]);
      halves(4);
      p = (180 - pa[i] * 9 / 5) * HALF / 180;
      chk(riseAt, p, p + 12);
    end
    enableIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({31'h0, gateDrive}, 0, 0);
    n0 = onHalves;
    halves(3);
    chk(onHalves, n0, n0 + 1);
    apb(1'b1, `REG_CTRL, 32'h3);
    apb(1'b1, `REG_SETPOINT, 32'h3C);
    enableIn <= 1'b1;
    repeat (20) @(posedge clk_sys);
    lvl(0, 10);
    repeat (2500) @(posedge clk_sys);
    lvl(60, 60);
    apb(1'b1, `REG_SETPOINT, 32'h14);
    lvl(50, 60);
    repeat (2500) @(posedge clk_sys);
    lvl(20, 20);
    enableIn <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h0);
    apb(1'b1, `REG_RAMP, 32'h0);
    apb(1'b1, `REG_BURST, 32'h2);
    apb(1'b1, `REG_DELAY, 32'h00000132);
    apb(1'b1, `REG_SETPOINT, 32'h19);
    enableIn <= 1'b1;
    halves(32);
    n0 = onHalves;
    halves(32);
    chk(onHalves - n0, 8, 8);
    chk(lastRun, 4, 4);
    chk(burstRise, 100, 112);
    chk(contRise, 0, 12);
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b1, `REG_SETPOINT, 32'h32);
    halves(16);
    n0 = onHalves;
    p = posOn - negOn;
    halves(32);
    chk(onHalves - n0, 15, 17);
    chk(posOn - negOn - p + 1, 0, 2);
    apb(1'b1, `REG_SETPOINT, 32'h64);
    halves(4);
    n0 = onHalves;
    halves(16);
    chk(onHalves - n0, 16, 16);
    // Half-cycle mode must filter a set point drop through the ramp
    apb(1'b1, `REG_RAMP, 32'h14);
    apb(1'b1, `REG_SETPOINT, 32'h32);
    lvl(95, 100);
    repeat (2500) @(posedge clk_sys);
    lvl(50, 50);
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
